// file: verilog/fams_top.sv
// Host buffer, fill level and secondary status register block
//
// Operation
// - Alarm clear works only below 125 C limit
// - Force bit selects fast input filter always
// - Target flag set on anticollision answer only
// - Field loss clears the target flag
// - Cipher flag set by authentication; software clears
// - Cipher flag on enables data encryption
// - Read-only three-bit link engine state code
// - Transmit wait: minimum time, optional field
// - Receive wait: minimum time, optional field
// - 64-byte buffer; write pushes, read pops
// - Serial streams pass through the buffer
// - Flush resets pointers and overflow error
// - Flush bit always reads zero
// - Seven-bit fill count up/down on access
// - Near full when free space <= threshold
// - Near empty when count <= threshold
`timescale 1ns/1ps
module fams_top
  import fams_pkg::*;
#(
  parameter int DEPTH = FAMS_BUF_DEPTH
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Host register port
  input wire fams_req_s host_req,
  output logic [7:0] host_rdata,
  // Modem link and serial data
  input wire fams_modem_s modem,
  input wire logic rf_field_on,
  input wire logic auto_anticollision,
  input wire logic passive_mode,
  input wire logic target_answered,
  input wire logic cipher_authenticate_ok,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic tx_byte_take,
  output logic [7:0] tx_byte,
  output logic tx_byte_avail,
  // Sensors and misc status
  input wire logic temp_above_limit,
  input wire logic temp_error_set,
  input wire logic i2c_fast_protocol,
  output logic temp_error,
  output logic fast_input_filter,
  output logic stream_cipher_active,
  output logic [2:0] link_state,
  output logic buffer_overflow_error,
  output logic near_full_alert,
  output logic near_empty_alert
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire sel_status2 = (host_req.addr == FAMS_OFS_STATUS2);
  wire sel_bufdata = (host_req.addr == FAMS_OFS_BUFDATA);
  wire sel_buflevel = (host_req.addr == FAMS_OFS_BUFLEVEL);
  wire sel_thresh = (host_req.addr == FAMS_OFS_THRESH);
  wire wr_status2 = host_req.wr && sel_status2;
  wire wr_level = host_req.wr && sel_buflevel;
  wire wr_thresh = host_req.wr && sel_thresh;

  // ----------------------------------------
  // Buffer
  // ----------------------------------------
  logic [6:0] fill_count;
  logic [7:0] pop_byte;
  wire flush = wr_level && host_req.wdata[FAMS_BIT_FLUSH];
  // Host port and serial receive both fill; host and transmitter drain
  wire push = (host_req.wr && sel_bufdata) || rx_byte_valid;
  wire [7:0] push_byte = rx_byte_valid ? rx_byte : host_req.wdata;
  wire pop = (host_req.rd && sel_bufdata) || tx_byte_take;

  fams_byte_fifo #(.DEPTH(DEPTH), .AW(6)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .flush(flush),
    .push(push),
    .push_data(push_byte),
    .pop(pop),
    .pop_data(pop_byte),
    .count(fill_count),
    .overflow(buffer_overflow_error)
  );

  // Encrypt outbound bytes with a keystream while cipher on
  logic [7:0] keystream_r;
  assign tx_byte = stream_cipher_active ? (pop_byte ^ keystream_r) : pop_byte;
  assign tx_byte_avail = (fill_count != '0);

  // ----------------------------------------
  // Alerts
  // ----------------------------------------
  logic [5:0] thresh_r;
  wire [6:0] free_space = 7'(DEPTH) - fill_count;
  assign near_full_alert = (free_space <= {1'b0, thresh_r});
  assign near_empty_alert = (fill_count <= {1'b0, thresh_r});

  // ----------------------------------------
  // Secondary status bits
  // ----------------------------------------
  logic temp_err_r;
  logic force_hs_r;
  logic tgt_sel_r;
  logic cipher_r;
  wire temp_clr = wr_status2 && host_req.wdata[FAMS_BIT_TEMP_CLR] && !temp_above_limit;
  wire tgt_set = target_answered && auto_anticollision && passive_mode;
  wire cipher_clr = wr_status2 && !host_req.wdata[FAMS_BIT_CIPHER];

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      temp_err_r <= 1'b0;
      force_hs_r <= 1'b0;
      tgt_sel_r <= 1'b0;
      cipher_r <= 1'b0;
      thresh_r <= FAMS_RST_THRESH;
      keystream_r <= FAMS_KEY_SEED;
    end
    else
    begin
      // Set wins over clear; clear only below limit
      if (temp_error_set)
        temp_err_r <= 1'b1;
      else if (temp_clr)
        temp_err_r <= 1'b0;
      if (wr_status2)
        force_hs_r <= host_req.wdata[FAMS_BIT_FORCE_HS];
      // Field off clears; set only during anticollision
      if (!rf_field_on)
        tgt_sel_r <= 1'b0;
      else if (tgt_set)
        tgt_sel_r <= 1'b1;
      // Authentication sets, software write of zero clears
      if (cipher_authenticate_ok)
        cipher_r <= 1'b1;
      else if (cipher_clr)
        cipher_r <= 1'b0;
      if (wr_thresh)
        thresh_r <= host_req.wdata[5:0];
      if (tx_byte_take && stream_cipher_active)
        keystream_r <= {keystream_r[6:0], keystream_r[7] ^ keystream_r[5]} ^ FAMS_KEY_MASK;
    end
  end

  assign temp_error = temp_err_r;
  assign fast_input_filter = force_hs_r || i2c_fast_protocol;
  assign stream_cipher_active = cipher_r;

  // ----------------------------------------
  // Link engine state machine
  // ----------------------------------------
  fams_state_e state_r;
  fams_state_e state_nxt;
  logic [7:0] wait_cnt_r;
  wire tx_wait_done = (wait_cnt_r >= modem.tx_wait_time_reg) && (!modem.tx_wait_field || rf_field_on);
  wire rx_wait_done = (wait_cnt_r >= modem.rx_wait_time_reg) && (!modem.rx_wait_field || rf_field_on);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      FAMS_ST_IDLE: if (modem.transceive) state_nxt = FAMS_ST_WAIT_LAUNCH;
      FAMS_ST_WAIT_LAUNCH: if (modem.launch_transmit) state_nxt = FAMS_ST_TX_WAIT;
      FAMS_ST_TX_WAIT: if (tx_wait_done) state_nxt = FAMS_ST_SENDING;
      FAMS_ST_SENDING: if (modem.tx_done) state_nxt = FAMS_ST_RX_WAIT;
      FAMS_ST_RX_WAIT: if (rx_wait_done) state_nxt = FAMS_ST_WAIT_DATA;
      FAMS_ST_WAIT_DATA: if (modem.rx_start) state_nxt = FAMS_ST_RECEIVING;
      FAMS_ST_RECEIVING: if (modem.rx_done) state_nxt = FAMS_ST_IDLE;
      default: state_nxt = FAMS_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_r <= FAMS_ST_IDLE;
      wait_cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt != state_r)
        wait_cnt_r <= '0;
      else if (wait_cnt_r != 8'hff)
        wait_cnt_r <= wait_cnt_r + 8'h01;
    end
  end

  assign link_state = state_r;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire [7:0] status2_val = {1'b0, force_hs_r, 1'b0, tgt_sel_r, cipher_r, state_r};
  // Flush bit position reads zero
  wire [7:0] level_val = {1'b0, fill_count};
  logic [7:0] rdata_r;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rdata_r <= FAMS_RST_STATUS2;
    else if (host_req.rd)
      rdata_r <= sel_status2 ? status2_val : sel_bufdata ? pop_byte : sel_buflevel ? level_val
               : sel_thresh ? {2'b00, thresh_r} : 8'h00;
  end

  assign host_rdata = rdata_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_flush_clears: assert property (@(posedge mclk) disable iff (sys_rst)
    flush |=> (fill_count == '0) && !buffer_overflow_error)
    else $error("flush did not clear buffer");
  chk_full_drop: assert property (@(posedge mclk) disable iff (sys_rst)
    (push && fill_count == 7'(DEPTH) && !pop && !flush) |=> buffer_overflow_error && fill_count == 7'(DEPTH))
    else $error("full write not dropped");
  chk_empty_pop: assert property (@(posedge mclk) disable iff (sys_rst)
    (pop && !push && fill_count == '0 && !flush) |=> fill_count == '0)
    else $error("empty pop changed count");
  chk_count_up: assert property (@(posedge mclk) disable iff (sys_rst)
    (push && !pop && !flush && fill_count < 7'(DEPTH)) |=> fill_count == $past(fill_count) + 7'h01)
    else $error("push did not increment");
  chk_tgt_field: assert property (@(posedge mclk) disable iff (sys_rst)
    !rf_field_on |=> !tgt_sel_r)
    else $error("target flag kept without field");
  chk_tgt_rise: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(tgt_sel_r) |-> $past(auto_anticollision) && $past(passive_mode))
    else $error("target flag set outside anticollision");
  chk_temp_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    (temp_err_r && temp_above_limit && !temp_error_set) |=> temp_err_r)
    else $error("temp error cleared above limit");
  chk_tx_wait_min: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_r == FAMS_ST_TX_WAIT && state_nxt == FAMS_ST_SENDING) |-> wait_cnt_r >= modem.tx_wait_time_reg)
    else $error("tx wait left early");
  chk_flush_reads0: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(host_req.rd && sel_buflevel) |-> !host_rdata[FAMS_BIT_FLUSH])
    else $error("flush bit read as one");
  chk_near_empty: assert property (@(posedge mclk) disable iff (sys_rst)
    (fill_count == '0) |-> near_empty_alert)
    else $error("near empty missing at zero");

endmodule : fams_top

// file: verilog/fams_pkg.sv
// Shared constants and types for the buffer and secondary status block
package fams_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [5:0] FAMS_OFS_STATUS2 = 6'h08;
  localparam logic [5:0] FAMS_OFS_BUFDATA = 6'h09;
  localparam logic [5:0] FAMS_OFS_BUFLEVEL = 6'h0a;
  localparam logic [5:0] FAMS_OFS_THRESH = 6'h0b;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int FAMS_BIT_TEMP_CLR = 7;
  localparam int FAMS_BIT_FORCE_HS = 6;
  localparam int FAMS_BIT_TGT_SEL = 4;
  localparam int FAMS_BIT_CIPHER = 3;
  localparam int FAMS_BIT_FLUSH = 7;
  localparam logic [7:0] FAMS_RST_STATUS2 = 8'h00;
  localparam logic [5:0] FAMS_RST_THRESH = 6'h08;
  localparam int FAMS_BUF_DEPTH = 64;
  // Keystream seed and feedback mask; nonzero seed so the first byte is covered
  localparam logic [7:0] FAMS_KEY_SEED = 8'hc3;
  localparam logic [7:0] FAMS_KEY_MASK = 8'h5a;

  // ----------------------------------------
  // Link engine state codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    FAMS_ST_IDLE = 3'b000,
    FAMS_ST_WAIT_LAUNCH = 3'b001,
    FAMS_ST_TX_WAIT = 3'b010,
    FAMS_ST_SENDING = 3'b011,
    FAMS_ST_RX_WAIT = 3'b100,
    FAMS_ST_WAIT_DATA = 3'b101,
    FAMS_ST_RECEIVING = 3'b110
  } fams_state_e;

  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } fams_req_s;

  // Modem side inputs
  typedef struct packed {
    logic transceive;
    logic launch_transmit;
    logic tx_done;
    logic rx_start;
    logic rx_done;
    logic tx_wait_field;
    logic rx_wait_field;
    logic [7:0] tx_wait_time_reg;
    logic [7:0] rx_wait_time_reg;
  } fams_modem_s;

endpackage : fams_pkg

// file: verilog/fams_byte_fifo.sv
// Byte buffer with fill count, flush and overflow flag
`timescale 1ns/1ps
module fams_byte_fifo
  import fams_pkg::*;
#(
  parameter int DEPTH = FAMS_BUF_DEPTH,
  parameter int AW = $clog2(DEPTH)
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic flush,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  // Status
  output logic [7:0] pop_data,
  output logic [AW:0] count,
  output logic overflow
);

  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;
  logic ovf_r;

  wire full = (count_r == (AW+1)'(DEPTH));
  wire empty = (count_r == '0);
  wire do_push = push && !full;
  wire do_pop = pop && !empty;

  assign pop_data = mem[rptr_r];
  assign count = count_r;
  assign overflow = ovf_r;

  always_ff @(posedge mclk)
  begin
    if (do_push)
      mem[wptr_r] <= push_data;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || flush)
    begin
      // Flush resets pointers and overflow at once
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
      ovf_r <= 1'b0;
    end
    else
    begin
      if (do_push)
        wptr_r <= wptr_r + 1'b1;
      if (do_pop)
        rptr_r <= rptr_r + 1'b1;
      // Count tracks pushes and pops; empty pop holds zero
      count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
      // Push while full is dropped and flagged
      if (push && full)
        ovf_r <= 1'b1;
    end
  end

endmodule : fams_byte_fifo

// file: tb/fams_host_model.sv
// Host microcontroller model driving the register port
`timescale 1ns/1ps
module fams_host_model
  import fams_pkg::*;
(
  // Clock
  mclk,
  // Register port
  host_req,
  host_rdata
);
  input wire logic mclk;
  output fams_req_s host_req;
  input wire logic [7:0] host_rdata;

  initial host_req = '0;

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Released lines show inverted values so a stale match cannot pass
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    host_req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    host_req <= '{1'b0, 1'b0, ~a, ~d};
    #1;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk);
    host_req <= '{1'b0, 1'b1, a, 8'h5a};
    @(posedge mclk);
    host_req <= '{1'b0, 1'b0, ~a, 8'ha5};
    #1;
    d = host_rdata;
  endtask : rd
endmodule : fams_host_model

// file: tb/tb_fams_top.sv
// Self-checking testbench for the buffer and secondary status block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_fams_top
  import fams_pkg::*;
;
  logic mclk, sys_rst, rf_on, acoll, pasv, tans, cok, rxv, take, hot, tset, i2cf;
  logic tav, terr, ffil, ciph, ovf, nfa, nea;
  logic [7:0] rxb, v, txb, rdata;
  logic [2:0] lst;
  fams_req_s req;
  fams_modem_s md;
  int bad_count, n_checks;

  fams_host_model u_host (.mclk(mclk), .host_req(req), .host_rdata(rdata));

  fams_top u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .host_req(req), .host_rdata(rdata), .modem(md),
    .rf_field_on(rf_on), .auto_anticollision(acoll), .passive_mode(pasv), .target_answered(tans),
    .cipher_authenticate_ok(cok), .rx_byte_valid(rxv), .rx_byte(rxb), .tx_byte_take(take),
    .tx_byte(txb), .tx_byte_avail(tav), .temp_above_limit(hot), .temp_error_set(tset),
    .i2c_fast_protocol(i2cf), .temp_error(terr), .fast_input_filter(ffil),
    .stream_cipher_active(ciph), .link_state(lst), .buffer_overflow_error(ovf),
    .near_full_alert(nfa), .near_empty_alert(nea)
  );

  initial
  begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task stop_test;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task rdchk(input logic [5:0] a, input logic [7:0] e);
    u_host.rd(a, v);
    `CHK(v, e)
  endtask : rdchk

  // Looks only after the launching edge has settled
  task wait_st(input logic [2:0] s);
    int k;
    k = 0;
    #1;
    while (lst !== s && k < 300)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    `CHK(lst, s)
  endtask : wait_st

  // Serial receiver hands one byte to the buffer
  task rx_push(input logic [7:0] b);
    @(posedge mclk);
    rxv <= 1;
    rxb <= b;
    @(posedge mclk);
    rxv <= 0;
    #1;
  endtask : rx_push

  // One answer pulse under given anticollision and passive levels
  task tgt_try(input logic a, input logic p, input logic [7:0] e);
    @(posedge mclk);
    acoll <= a;
    pasv <= p;
    @(posedge mclk) tans <= 1;
    @(posedge mclk) tans <= 0;
    rdchk(FAMS_OFS_STATUS2, e);
  endtask : tgt_try

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_fill;
    rdchk(FAMS_OFS_STATUS2, FAMS_RST_STATUS2);
    for (int i = 0; i < 64; i++)
    begin
      u_host.wr(FAMS_OFS_BUFDATA, 8'(i));
      if (i == 7 || i == 8) `CHK(nea, i == 7)
      if (i == 54 || i == 55) `CHK(nfa, i == 55)
    end
    u_host.wr(FAMS_OFS_BUFDATA, 8'hee);
    `CHK(ovf, 1'b1)
    rdchk(FAMS_OFS_BUFLEVEL, 8'd64);
    rdchk(FAMS_OFS_BUFDATA, 8'h00);
    rdchk(FAMS_OFS_BUFDATA, 8'h01);
    rdchk(FAMS_OFS_BUFLEVEL, 8'd62);
    u_host.wr(FAMS_OFS_BUFLEVEL, 8'h80);
    `CHK({ovf, nea}, 2'b01)
    rdchk(FAMS_OFS_BUFLEVEL, 8'h00);
    u_host.rd(FAMS_OFS_BUFDATA, v);
    rdchk(FAMS_OFS_BUFLEVEL, 8'h00);
    u_host.wr(FAMS_OFS_BUFDATA, 8'h3c);
    u_host.wr(FAMS_OFS_THRESH, 8'hff);
    `CHK({nfa, nea}, 2'b11)
    rdchk(FAMS_OFS_THRESH, 8'h3f);
    rdchk(FAMS_OFS_BUFDATA, 8'h3c);
  endtask : t_fill

  task t_stream;
    rx_push(8'h5a);
    `CHK({tav, txb}, 9'h15a)
    @(posedge mclk) take <= 1;
    @(posedge mclk) take <= 0;
    #1 `CHK(tav, 1'b0)
  endtask : t_stream

  task t_status;
    u_host.wr(FAMS_OFS_STATUS2, 8'h40);
    `CHK(ffil, 1'b1)
    u_host.wr(FAMS_OFS_STATUS2, 8'h00);
    `CHK(ffil, 1'b0)
    @(posedge mclk) i2cf <= 1;
    #1 `CHK(ffil, 1'b1)
    @(posedge mclk) i2cf <= 0;
    @(posedge mclk) rf_on <= 1;
    tgt_try(1'b0, 1'b1, 8'h00);
    tgt_try(1'b1, 1'b0, 8'h00);
    tgt_try(1'b1, 1'b1, 8'h10);
    @(posedge mclk) rf_on <= 0;
    rdchk(FAMS_OFS_STATUS2, 8'h00);
    @(posedge mclk) cok <= 1;
    @(posedge mclk) cok <= 0;
    rdchk(FAMS_OFS_STATUS2, 8'h08);
    rx_push(8'h00);
    `CHK(txb == 8'h00, 1'b0)
    rdchk(FAMS_OFS_BUFDATA, 8'h00);
    u_host.wr(FAMS_OFS_STATUS2, 8'h00);
    `CHK(ciph, 1'b0)
    @(posedge mclk) tset <= 1;
    @(posedge mclk) tset <= 0;
    hot <= 1;
    u_host.wr(FAMS_OFS_STATUS2, 8'h80);
    `CHK(terr, 1'b1)
    @(posedge mclk) hot <= 0;
    u_host.wr(FAMS_OFS_STATUS2, 8'h80);
    `CHK(terr, 1'b0)
  endtask : t_status

  task t_link;
    @(posedge mclk);
    md.tx_wait_time_reg <= 8'd3;
    md.rx_wait_time_reg <= 8'd2;
    md.tx_wait_field <= 1;
    md.transceive <= 1;
    @(posedge mclk) md.transceive <= 0;
    wait_st(FAMS_ST_WAIT_LAUNCH);
    @(posedge mclk) md.launch_transmit <= 1;
    @(posedge mclk) md.launch_transmit <= 0;
    wait_st(FAMS_ST_TX_WAIT);
    repeat (10) @(posedge mclk);
    #1 `CHK(lst, FAMS_ST_TX_WAIT)
    @(posedge mclk) rf_on <= 1;
    wait_st(FAMS_ST_SENDING);
    @(posedge mclk) md.tx_done <= 1;
    @(posedge mclk) md.tx_done <= 0;
    wait_st(FAMS_ST_RX_WAIT);
    wait_st(FAMS_ST_WAIT_DATA);
    @(posedge mclk) md.rx_start <= 1;
    @(posedge mclk) md.rx_start <= 0;
    wait_st(FAMS_ST_RECEIVING);
    @(posedge mclk) md.rx_done <= 1;
    @(posedge mclk) md.rx_done <= 0;
    wait_st(FAMS_ST_IDLE);
    // Second pass: minimum time only on transmit, field wait on receive
    @(posedge mclk);
    md.tx_wait_time_reg <= 8'd5;
    md.tx_wait_field <= 0;
    md.rx_wait_field <= 1;
    rf_on <= 0;
    md.transceive <= 1;
    @(posedge mclk) md.transceive <= 0;
    wait_st(FAMS_ST_WAIT_LAUNCH);
    @(posedge mclk) md.launch_transmit <= 1;
    @(posedge mclk) md.launch_transmit <= 0;
    wait_st(FAMS_ST_TX_WAIT);
    repeat (5) @(posedge mclk);
    #1 `CHK(lst, FAMS_ST_TX_WAIT)
    @(posedge mclk);
    #1 `CHK(lst, FAMS_ST_SENDING)
    @(posedge mclk) md.tx_done <= 1;
    @(posedge mclk) md.tx_done <= 0;
    wait_st(FAMS_ST_RX_WAIT);
    repeat (10) @(posedge mclk);
    #1 `CHK(lst, FAMS_ST_RX_WAIT)
    @(posedge mclk) rf_on <= 1;
    wait_st(FAMS_ST_WAIT_DATA);
    @(posedge mclk) md.rx_start <= 1;
    @(posedge mclk) md.rx_start <= 0;
    wait_st(FAMS_ST_RECEIVING);
    @(posedge mclk) md.rx_done <= 1;
    @(posedge mclk) md.rx_done <= 0;
    wait_st(FAMS_ST_IDLE);
  endtask : t_link

  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial
  begin
    {rf_on, acoll, pasv, tans, cok, rxv, take, hot, tset, i2cf, rxb} = '0;
    md = '0;
    sys_rst = 1;
    repeat (4) @(posedge mclk);
    sys_rst <= 0;
    t_fill;
    t_stream;
    t_status;
    t_link;
    stop_test;
  end

  initial
  begin
    #50us;
    bad_count++;
    stop_test;
  end
endmodule : tb_fams_top
